// ---- hw/modem_special_command_status.sv ----
// Function
// - Written 8-bit opcode requests a special task
// - Completion sets done flag; then host reads
// - Task runs at next sequencer idle slot
// - Opcode 00 does nothing
// - 01/09/0A/0B load coefficient pointer
// - 0C pokes memory, 0D peeks memory
// - 11/12 enter setup; 12 waits sample tick
// - 13/14 leave setup; 14 also reinitialises
// - 15 loads rx filter from pointer
// - 1A selects BT 0.3, 1B 0.5
// - 18 sets decode threshold, default 2400
// - Bit 6 flags rx filter overflow
// - Overflow flag clears when read
// - Overflow flag raises no interrupt
// - I readback bits 5:0 coarse I offset
// - Q readback bits 7:6 AGC step
// - Q readback bits 5:0 coarse Q offset
// - Aux MSB read latches low bits
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module modem_special_command_status
    import modem_spc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [15:0] TX_FILTER_BASE = 16'h0040,
    parameter logic [15:0] RX_CHANNEL_BASE = 16'h0080,
    parameter logic [15:0] RX_GAUSS_BASE = 16'h00C0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    // Sequencer timing
    input wire logic seqIdle,
    input wire logic sampleTick,
    // Receive datapath status
    input wire logic [7:0] rxData,
    input wire logic [6:0] status1Flags,
    input wire logic irqActive,
    input wire logic [7:0] qualityLevel,
    input wire logic [7:0] signalLevel,
    input wire logic [6:0] carrierOffset,
    input wire logic carrierOffsetValid,
    input wire logic rxFilterOverflow,
    input wire logic [5:0] coarseOffsetI,
    input wire logic [5:0] coarseOffsetQ,
    input wire logic [1:0] agcStep,
    input wire logic lockLost,
    input wire logic auxConvDone,
    input wire logic freqOffsetError,
    input wire logic iqOffsetDone,
    // Lock pins from the synthesisers
    input wire logic mainLockPin,
    input wire logic auxLockPin,
    input wire logic txLockPin,
    // Aux converter results
    input wire logic [9:0] auxResult0,
    input wire logic [9:0] auxResult1,
    input wire logic [9:0] auxResult2,
    // Controls to the modem core
    output logic [15:0] coefficientPointer,
    output logic btHalf,
    output logic [15:0] decodeThreshold,
    output logic [15:0] afcLimit,
    output logic setupMode,
    output logic modemInit,
    output logic branchReq,
    output logic [15:0] branchAddr,
    output logic loadRxFilter,
    output logic cmdComplete
);
    import modem_spc_pkg::*;

    localparam int MEM_DEPTH = 1 << ADDR_W;

    if (ADDR_W < 4 || ADDR_W > 16) begin : gBadAddrW
        $error("ADDR_W must lie in 4..16");
    end

    logic [15:0] coefMem [0:MEM_DEPTH-1];
    logic [7:0] opcode_reg;
    logic [15:0] operandHigh_reg;
    logic [15:0] operandLow_reg;
    seq_state_type seqState_reg;
    seq_state_type seqState_next;
    logic overflow_reg;
    logic [2:0] lockSync;
    logic [7:0] auxMsb [0:2];
    logic [7:0] auxLsb [0:2];
    logic [2:0] auxMsbRead;
    logic execute;
    logic finishSync;
    logic taskDone;
    logic opcodeWrite;
    logic readI;
    logic [ADDR_W-1:0] memIndex;

    assign opcodeWrite = wrStb && (addr == ADDR_OPCODE);
    assign readI = rdStb && (addr == ADDR_I_READBACK);
    assign memIndex = operandLow_reg[ADDR_W-1:0];

    level_sync #(
        .WIDTH(3)
    ) lockSyncInst (
        .clk(clk),
        .rst(rst),
        .asyncIn({mainLockPin, auxLockPin, txLockPin}),
        .syncOut(lockSync)
    );

    assign auxMsbRead[0] = rdStb && (addr == ADDR_AUX0_MSB);
    assign auxMsbRead[1] = rdStb && (addr == ADDR_AUX1_MSB);
    assign auxMsbRead[2] = rdStb && (addr == ADDR_AUX2_MSB);

    aux_result_hold auxHold0 (
        .clk(clk),
        .rst(rst),
        .result(auxResult0),
        .msbRead(auxMsbRead[0]),
        .msbByte(auxMsb[0]),
        .lsbByte(auxLsb[0])
    );

    aux_result_hold auxHold1 (
        .clk(clk),
        .rst(rst),
        .result(auxResult1),
        .msbRead(auxMsbRead[1]),
        .msbByte(auxMsb[1]),
        .lsbByte(auxLsb[1])
    );

    aux_result_hold auxHold2 (
        .clk(clk),
        .rst(rst),
        .result(auxResult2),
        .msbRead(auxMsbRead[2]),
        .msbByte(auxMsb[2]),
        .lsbByte(auxLsb[2])
    );

    // Sequencer: a pending opcode waits for a gap in processing
    always_comb begin
        seqState_next = seqState_reg;
        execute = 1'b0;
        finishSync = 1'b0;
        case (seqState_reg)
            SEQ_IDLE: begin
                if (opcode_reg != OP_NULL && !opcodeWrite) begin
                    seqState_next = SEQ_PENDING;
                end
            end
            SEQ_PENDING: begin
                if (opcodeWrite) begin
                    seqState_next = SEQ_IDLE;
                end else if (seqIdle) begin
                    execute = 1'b1;
                    if (opcode_reg == OP_ENTER_SETUP_SYNC) begin
                        seqState_next = SEQ_SYNC;
                    end else begin
                        seqState_next = SEQ_IDLE;
                    end
                end
            end
            SEQ_SYNC: begin
                // A new opcode abandons the wait so it is not wiped by the late finish
                if (opcodeWrite) begin
                    seqState_next = SEQ_IDLE;
                end else if (sampleTick) begin
                    finishSync = 1'b1;
                    seqState_next = SEQ_IDLE;
                end
            end
            default: begin
                seqState_next = SEQ_IDLE;
            end
        endcase
    end

    assign taskDone = (execute && opcode_reg != OP_ENTER_SETUP_SYNC) || finishSync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seqState_reg <= SEQ_IDLE;
        end else begin
            seqState_reg <= seqState_next;
        end
    end

    // Opcode register, emptied once its task has run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opcode_reg <= OP_NULL;
        end else if (opcodeWrite) begin
            opcode_reg <= wrData;
        end else if (taskDone) begin
            opcode_reg <= OP_NULL;
        end
    end

    // Done flag: a completion in the write cycle still sets it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdComplete <= 1'b0;
        end else if (taskDone) begin
            cmdComplete <= 1'b1;
        end else if (opcodeWrite) begin
            cmdComplete <= 1'b0;
        end
    end

    // Operand words; a peek result takes priority over a host write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            operandHigh_reg <= 16'h0000;
            operandLow_reg <= 16'h0000;
        end else begin
            if (wrStb && addr == ADDR_OPND_HIGH_MSB) begin
                operandHigh_reg[15:8] <= wrData;
            end
            if (wrStb && addr == ADDR_OPND_HIGH_LSB) begin
                operandHigh_reg[7:0] <= wrData;
            end
            if (execute && opcode_reg == OP_PEEK) begin
                operandLow_reg <= coefMem[memIndex];
            end else begin
                if (wrStb && addr == ADDR_OPND_LOW_MSB) begin
                    operandLow_reg[15:8] <= wrData;
                end
                if (wrStb && addr == ADDR_OPND_LOW_LSB) begin
                    operandLow_reg[7:0] <= wrData;
                end
            end
        end
    end

    // Coefficient memory has no reset; software fills it by poke
    always_ff @(posedge clk) begin
        if (execute && opcode_reg == OP_POKE) begin
            coefMem[memIndex] <= operandHigh_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coefficientPointer <= 16'h0000;
        end else if (execute) begin
            case (opcode_reg)
                OP_SET_POINTER: coefficientPointer <= operandLow_reg;
                OP_PTR_TX_FILTER: coefficientPointer <= TX_FILTER_BASE;
                OP_PTR_RX_CHANNEL: coefficientPointer <= RX_CHANNEL_BASE;
                OP_PTR_RX_GAUSS: coefficientPointer <= RX_GAUSS_BASE;
                default: coefficientPointer <= coefficientPointer;
            endcase
        end
    end

    // Setup mode: 12 enters only on the sample tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setupMode <= 1'b0;
        end else if (finishSync) begin
            setupMode <= 1'b1;
        end else if (execute) begin
            case (opcode_reg)
                OP_ENTER_SETUP: setupMode <= 1'b1;
                OP_EXIT_SETUP: setupMode <= 1'b0;
                OP_EXIT_SETUP_INIT: setupMode <= 1'b0;
                default: setupMode <= setupMode;
            endcase
        end
    end

    // One-cycle requests to the modem core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modemInit <= 1'b0;
            branchReq <= 1'b0;
            loadRxFilter <= 1'b0;
            branchAddr <= 16'h0000;
        end else begin
            modemInit <= execute && opcode_reg == OP_EXIT_SETUP_INIT;
            branchReq <= execute && opcode_reg == OP_BRANCH;
            loadRxFilter <= execute && opcode_reg == OP_LOAD_RX_FILTER;
            if (execute && opcode_reg == OP_BRANCH) begin
                branchAddr <= operandLow_reg;
            end
        end
    end

    // Modem settings; opcode 00 and unknown codes touch none of them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            btHalf <= BT_RESET;
            decodeThreshold <= THRESHOLD_RESET;
            afcLimit <= AFC_LIMIT_RESET;
        end else if (execute) begin
            case (opcode_reg)
                OP_BT_LOW: btHalf <= 1'b0;
                OP_BT_HIGH: btHalf <= 1'b1;
                OP_SET_THRESHOLD: decodeThreshold <= operandLow_reg;
                OP_AFC_LIMIT: afcLimit <= operandLow_reg;
                default: btHalf <= btHalf;
            endcase
        end
    end

    // Overflow flag: test aid only, never routed to an interrupt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_reg <= 1'b0;
        end else if (rxFilterOverflow) begin
            overflow_reg <= 1'b1;
        end else if (readI) begin
            overflow_reg <= 1'b0;
        end
    end

    // Read port: data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (!rdStb) begin
            rdData <= 8'h00;
        end else begin
            case (addr)
                ADDR_RX_DATA: rdData <= rxData;
                ADDR_STATUS_ONE: rdData <= {irqActive, status1Flags};
                ADDR_QUALITY: rdData <= qualityLevel;
                ADDR_STATUS_TWO: rdData <= {lockLost, lockSync, cmdComplete,
                    auxConvDone, freqOffsetError, iqOffsetDone};
                ADDR_CARRIER_OFFSET: rdData <= {carrierOffset, carrierOffsetValid};
                ADDR_SIGNAL_LEVEL: rdData <= signalLevel;
                ADDR_AUX0_LSB: rdData <= auxLsb[0];
                ADDR_AUX0_MSB: rdData <= auxMsb[0];
                ADDR_AUX1_LSB: rdData <= auxLsb[1];
                ADDR_AUX1_MSB: rdData <= auxMsb[1];
                ADDR_AUX2_LSB: rdData <= auxLsb[2];
                ADDR_AUX2_MSB: rdData <= auxMsb[2];
                ADDR_I_READBACK: rdData <= {1'b0, overflow_reg, coarseOffsetI};
                ADDR_Q_READBACK: rdData <= {agcStep, coarseOffsetQ};
                ADDR_OPND_HIGH_MSB: rdData <= operandHigh_reg[15:8];
                ADDR_OPND_HIGH_LSB: rdData <= operandHigh_reg[7:0];
                ADDR_OPND_LOW_MSB: rdData <= operandLow_reg[15:8];
                ADDR_OPND_LOW_LSB: rdData <= operandLow_reg[7:0];
                default: rdData <= 8'h00;
            endcase
        end
    end
endmodule // modem_special_command_status
`default_nettype wire

// ---- hw/modem_spc_pkg.sv ----
package modem_spc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_RX_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h01;
    localparam logic [7:0] ADDR_QUALITY = 8'h02;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h03;
    localparam logic [7:0] ADDR_CARRIER_OFFSET = 8'h04;
    localparam logic [7:0] ADDR_SIGNAL_LEVEL = 8'h05;
    localparam logic [7:0] ADDR_AUX0_LSB = 8'h08;
    localparam logic [7:0] ADDR_AUX0_MSB = 8'h09;
    localparam logic [7:0] ADDR_AUX1_LSB = 8'h0A;
    localparam logic [7:0] ADDR_AUX1_MSB = 8'h0B;
    localparam logic [7:0] ADDR_AUX2_LSB = 8'h0C;
    localparam logic [7:0] ADDR_AUX2_MSB = 8'h0D;
    localparam logic [7:0] ADDR_I_READBACK = 8'h18;
    localparam logic [7:0] ADDR_Q_READBACK = 8'h19;
    localparam logic [7:0] ADDR_OPCODE = 8'h1A;
    localparam logic [7:0] ADDR_OPND_HIGH_MSB = 8'h1B;
    localparam logic [7:0] ADDR_OPND_HIGH_LSB = 8'h1C;
    localparam logic [7:0] ADDR_OPND_LOW_MSB = 8'h1D;
    localparam logic [7:0] ADDR_OPND_LOW_LSB = 8'h1E;

    // Special task opcodes
    localparam logic [7:0] OP_NULL = 8'h00;
    localparam logic [7:0] OP_SET_POINTER = 8'h01;
    localparam logic [7:0] OP_PTR_TX_FILTER = 8'h09;
    localparam logic [7:0] OP_PTR_RX_CHANNEL = 8'h0A;
    localparam logic [7:0] OP_PTR_RX_GAUSS = 8'h0B;
    localparam logic [7:0] OP_POKE = 8'h0C;
    localparam logic [7:0] OP_PEEK = 8'h0D;
    localparam logic [7:0] OP_BRANCH = 8'h0E;
    localparam logic [7:0] OP_ENTER_SETUP = 8'h11;
    localparam logic [7:0] OP_ENTER_SETUP_SYNC = 8'h12;
    localparam logic [7:0] OP_EXIT_SETUP = 8'h13;
    localparam logic [7:0] OP_EXIT_SETUP_INIT = 8'h14;
    localparam logic [7:0] OP_LOAD_RX_FILTER = 8'h15;
    localparam logic [7:0] OP_SET_THRESHOLD = 8'h18;
    localparam logic [7:0] OP_BT_LOW = 8'h1A;
    localparam logic [7:0] OP_BT_HIGH = 8'h1B;
    localparam logic [7:0] OP_AFC_LIMIT = 8'h1C;

    // Field positions
    localparam int OVERFLOW_BIT = 6;
    localparam int STATUS_TWO_DONE_BIT = 3;

    // Reset values
    localparam logic [15:0] THRESHOLD_RESET = 16'h0960;
    localparam logic BT_RESET = 1'b0;
    localparam logic [15:0] AFC_LIMIT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_PENDING = 2'b01,
        SEQ_SYNC = 2'b10
    } seq_state_type;
endpackage

// ---- hw/level_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] firstStage_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            firstStage_reg <= '0;
            syncOut <= '0;
        end else begin
            firstStage_reg <= asyncIn;
            syncOut <= firstStage_reg;
        end
    end
endmodule // level_sync
`default_nettype wire

// ---- hw/aux_result_hold.sv ----
`timescale 1ns/1ps
`default_nettype none
module aux_result_hold (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Converter side
    input wire logic [9:0] result,
    // Register side
    input wire logic msbRead,
    output logic [7:0] msbByte,
    output logic [7:0] lsbByte
);
    logic [1:0] lowBits_reg;

    // Low bits frozen at the MSB read so both halves match one conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowBits_reg <= 2'h0;
        end else if (msbRead) begin
            lowBits_reg <= result[1:0];
        end
    end

    assign msbByte = result[9:2];
    assign lsbByte = {6'h00, lowBits_reg};
endmodule // aux_result_hold
`default_nettype wire

// ---- test/modem_spc_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module modem_spc_properties
    import modem_spc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [7:0] rdData,
    // Timing and readback inputs
    input wire logic seqIdle,
    input wire logic sampleTick,
    input wire logic [6:0] carrierOffset,
    input wire logic carrierOffsetValid,
    input wire logic rxFilterOverflow,
    input wire logic [5:0] coarseOffsetQ,
    input wire logic [1:0] agcStep,
    // Controls
    input wire logic [15:0] coefficientPointer,
    input wire logic btHalf,
    input wire logic [15:0] decodeThreshold,
    input wire logic setupMode,
    input wire logic modemInit,
    input wire logic loadRxFilter,
    input wire logic cmdComplete
);
    import modem_spc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic opWrite;
    logic rdI;
    assign opWrite = wrStb && addr == ADDR_OPCODE;
    assign rdI = rdStb && addr == ADDR_I_READBACK;

    a_null_no_done: assert property (opWrite && wrData == OP_NULL |=> !cmdComplete [*4])
        else $error("null opcode completed");
    a_write_clears_done: assert property (opWrite && !seqIdle && !sampleTick |=> !cmdComplete)
        else $error("done flag not cleared by opcode write");
    a_done_at_idle: assert property ($rose(cmdComplete) && !setupMode |-> $past(seqIdle))
        else $error("task completed outside an idle slot");
    a_pointer_cause: assert property ($changed(coefficientPointer) |-> $rose(cmdComplete))
        else $error("pointer moved without a task");
    a_bt_cause: assert property ($changed(btHalf) |-> $rose(cmdComplete))
        else $error("bandwidth select moved without a task");
    a_threshold_cause: assert property ($changed(decodeThreshold) |-> $rose(cmdComplete))
        else $error("threshold moved without a task");
    a_init_leaves_setup: assert property (modemInit |-> cmdComplete && !setupMode)
        else $error("init pulse without setup exit");
    a_filter_pulse: assert property (loadRxFilter |-> cmdComplete ##1 !loadRxFilter)
        else $error("filter load pulse malformed");
    a_q_readback: assert property (
        rdStb && addr == ADDR_Q_READBACK |=> rdData == {$past(agcStep), $past(coarseOffsetQ)})
        else $error("quadrature readback wrong");
    a_offset_read: assert property (rdStb && addr == ADDR_CARRIER_OFFSET
        |=> rdData == {$past(carrierOffset), $past(carrierOffsetValid)})
        else $error("carrier offset readback wrong");
    a_done_status: assert property (rdStb && addr == ADDR_STATUS_TWO
        |=> rdData[STATUS_TWO_DONE_BIT] == $past(cmdComplete))
        else $error("status done bit wrong");
    a_overflow_clear: assert property (
        rdI && !rxFilterOverflow ##1 !rxFilterOverflow ##1 rdI && !rxFilterOverflow |=> !rdData[OVERFLOW_BIT])
        else $error("overflow flag survived a read");

    c_peek: cover property (opWrite && wrData == OP_PEEK);
    c_setup: cover property ($rose(setupMode));
    c_init: cover property (modemInit);
endmodule // modem_spc_properties

bind modem_special_command_status modem_spc_properties u_props (.clk, .rst, .addr, .wrData, .wrStb, .rdStb,
    .rdData, .seqIdle, .sampleTick, .carrierOffset, .carrierOffsetValid, .rxFilterOverflow, .coarseOffsetQ,
    .agcStep, .coefficientPointer, .btHalf, .decodeThreshold, .setupMode, .modemInit, .loadRxFilter, .cmdComplete);
`default_nettype wire

// ---- test/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] addr,
    output logic [7:0] wrData,
    output logic wrStb,
    output logic rdStb,
    input wire logic [7:0] rdData
);
    initial begin
        addr = 8'h00;
        wrData = 8'h00;
        wrStb = 1'b0;
        rdStb = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
        // Stale data toggles so nothing leans on it
        wrData <= ~d;
    endtask
    // Operand words go high byte first; callers load them before the opcode
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 8'h01, v[7:0]);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        @(negedge clk);
        d = rdData;
    endtask
endmodule // host_bus_model
`default_nettype wire

// ---- test/modem_special_command_status_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module modem_special_command_status_test;
    import modem_spc_pkg::*;
    localparam logic [15:0] TX_BASE = 16'h0140;
    localparam logic [15:0] RXC_BASE = 16'h0280;
    localparam logic [15:0] RXG_BASE = 16'h03C0;
    logic clk = 1'b0, rst = 1'b1, wrStb, rdStb, seqIdle = 1'b0, sampleTick = 1'b0;
    logic [7:0] addr, wrData, rdData, rxData = 8'h3C, qualityLevel = 8'h9E, signalLevel = 8'h71, d;
    logic [6:0] status1Flags = 7'h55, carrierOffset = 7'h5A;
    logic irqActive = 1'b1, carrierOffsetValid = 1'b1, rxFilterOverflow = 1'b0, lockLost = 1'b0;
    logic auxConvDone = 1'b1, freqOffsetError = 1'b0, iqOffsetDone = 1'b1;
    logic mainLockPin = 1'b1, auxLockPin = 1'b0, txLockPin = 1'b1;
    logic [5:0] coarseOffsetI = 6'h2B, coarseOffsetQ = 6'h14;
    logic [1:0] agcStep = 2'h2;
    logic [9:0] auxResult0 = 10'h2A5, auxResult1 = 10'h1F3, auxResult2 = 10'h00E;
    logic [15:0] coefficientPointer, decodeThreshold, afcLimit, branchAddr;
    logic btHalf, setupMode, modemInit, loadRxFilter, cmdComplete, sawInit, sawLoad, got, branchReq, sawBranch;
    logic [2:0] cyc = 3'h0;
    int mismatches = 0;
    int samplesChecked = 0;

    host_bus_model u_host (.clk, .addr, .wrData, .wrStb, .rdStb, .rdData);
    modem_special_command_status #(.TX_FILTER_BASE(TX_BASE), .RX_CHANNEL_BASE(RXC_BASE),
        .RX_GAUSS_BASE(RXG_BASE)) u_dut (.clk, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData, .seqIdle,
        .sampleTick, .rxData, .status1Flags, .irqActive, .qualityLevel, .signalLevel, .carrierOffset,
        .carrierOffsetValid, .rxFilterOverflow, .coarseOffsetI, .coarseOffsetQ, .agcStep, .lockLost,
        .auxConvDone, .freqOffsetError, .iqOffsetDone, .mainLockPin, .auxLockPin, .txLockPin, .auxResult0,
        .auxResult1, .auxResult2, .coefficientPointer, .btHalf, .decodeThreshold, .afcLimit, .setupMode,
        .modemInit, .branchReq, .branchAddr, .loadRxFilter, .cmdComplete);

    always #20 clk = ~clk;
    // Sparse idle slots so tasks visibly wait for the sequencer
    always @(posedge clk) begin
        cyc <= cyc + 3'h1;
        seqIdle <= (cyc[1:0] == 2'b11);
        sampleTick <= (cyc == 3'h5);
    end

    task automatic summarize;
        $display("Checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rc(input string name, input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d);
        check(name, {8'h00, d}, {8'h00, exp});
    endtask
    // Waits for completion before any reply is read back
    task automatic op(input logic [7:0] c);
        u_host.wr(ADDR_OPCODE, c);
        sawInit = 1'b0;
        sawLoad = 1'b0;
        sawBranch = 1'b0;
        got = 1'b0;
        repeat (200) begin
            @(negedge clk);
            sawInit |= modemInit;
            sawLoad |= loadRxFilter;
            sawBranch |= branchReq;
            if (cmdComplete === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
        if (!got) begin
            mismatches++;
            summarize();
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("threshold", decodeThreshold, THRESHOLD_RESET);
        check("bt", {15'h0, btHalf}, {15'h0, BT_RESET});
        check("done", {15'h0, cmdComplete}, 16'h0000);
        $display("Test reset done");
        u_host.wr16(ADDR_OPND_LOW_MSB, 16'h1234);
        op(OP_SET_POINTER);
        check("pointer", coefficientPointer, 16'h1234);
        op(OP_PTR_TX_FILTER);
        check("pointer", coefficientPointer, TX_BASE);
        op(OP_PTR_RX_CHANNEL);
        check("pointer", coefficientPointer, RXC_BASE);
        op(OP_PTR_RX_GAUSS);
        check("pointer", coefficientPointer, RXG_BASE);
        op(8'h30);
        check("pointer", coefficientPointer, RXG_BASE);
        $display("Test pointer done");
        u_host.wr16(ADDR_OPND_HIGH_MSB, 16'hBEEF);
        u_host.wr16(ADDR_OPND_LOW_MSB, 16'h0005);
        op(OP_POKE);
        u_host.wr16(ADDR_OPND_HIGH_MSB, 16'h0000);
        op(OP_PEEK);
        rc("peek_msb", ADDR_OPND_LOW_MSB, 8'hBE);
        rc("peek_lsb", ADDR_OPND_LOW_LSB, 8'hEF);
        $display("Test memory done");
        op(OP_BT_HIGH);
        check("bt", {15'h0, btHalf}, 16'h0001);
        op(OP_BT_LOW);
        check("bt", {15'h0, btHalf}, 16'h0000);
        u_host.wr16(ADDR_OPND_LOW_MSB, 16'h0123);
        op(OP_SET_THRESHOLD);
        check("threshold", decodeThreshold, 16'h0123);
        u_host.wr16(ADDR_OPND_LOW_MSB, 16'h0A5C);
        op(OP_AFC_LIMIT);
        check("afc_limit", afcLimit, 16'h0A5C);
        op(OP_BRANCH);
        check("branch_addr", branchAddr, 16'h0A5C);
        check("branch_req", {15'h0, sawBranch}, 16'h0001);
        $display("Test modes done");
        op(OP_ENTER_SETUP);
        check("setup", {15'h0, setupMode}, 16'h0001);
        op(OP_EXIT_SETUP);
        check("setup", {15'h0, setupMode}, 16'h0000);
        op(OP_ENTER_SETUP_SYNC);
        check("setup", {15'h0, setupMode}, 16'h0001);
        op(OP_EXIT_SETUP_INIT);
        check("setup", {15'h0, setupMode}, 16'h0000);
        check("init", {15'h0, sawInit}, 16'h0001);
        op(OP_LOAD_RX_FILTER);
        check("filter_load", {15'h0, sawLoad}, 16'h0001);
        $display("Test setup done");
        @(posedge clk) rxFilterOverflow <= 1'b1;
        @(posedge clk) rxFilterOverflow <= 1'b0;
        rc("i_readback", ADDR_I_READBACK, {2'b01, coarseOffsetI});
        rc("i_readback", ADDR_I_READBACK, {2'b00, coarseOffsetI});
        rc("q_readback", ADDR_Q_READBACK, {agcStep, coarseOffsetQ});
        rc("carrier", ADDR_CARRIER_OFFSET, {carrierOffset, carrierOffsetValid});
        rc("status_two", ADDR_STATUS_TWO, {lockLost, mainLockPin, auxLockPin, txLockPin, 1'b1,
            auxConvDone, freqOffsetError, iqOffsetDone});
        rc("rx_data", ADDR_RX_DATA, rxData);
        rc("status_one", ADDR_STATUS_ONE, {irqActive, status1Flags});
        rc("quality", ADDR_QUALITY, qualityLevel);
        rc("signal", ADDR_SIGNAL_LEVEL, signalLevel);
        rc("unmapped", 8'h30, 8'h00);
        rc("aux_msb", ADDR_AUX0_MSB, 8'hA9);
        @(posedge clk) auxResult0 <= 10'h000;
        u_host.rd(ADDR_AUX0_LSB, d);
        check("aux_lsb", {8'h00, d}, 16'h0001);
        $display("Test readback done");
        u_host.wr(ADDR_OPCODE, OP_NULL);
        repeat (12) @(negedge clk);
        check("done", {15'h0, cmdComplete}, 16'h0000);
        $display("Test null done");
        summarize();
    end
endmodule // modem_special_command_status_test
`default_nettype wire
